// File: logic/dsadc_ctrl.sv
// dsadc_ctrl: clocking, decimation, result and flag logic of the converter
// assumes sys_clk at 100 MHz, one modulator bit sampled per converter tick
//
// Notes on behaviour
// - modulator reset bit holds modulator in reset
// - codes 0..30: source is clock/2/(code+1)
// - code 31: source is undivided clock
// - filter bit picks order, latency 3 or 4
// - chopper on when bit 0; software pairs
// - word rate: clock/(2*osr) or clock/osr
// - converter clock is source divided by 12/30
// - conversion starts after soft reset pulse
// - end-of-conversion flag set per published word, none while held
// - request flag set; irq needs both enables
// - results overwritten unless hold enabled
// - reserved control bits keep reset values
// - unimplemented bits read as zero
// - soft reset high holds filter, aborts conversion
// - osr code 0 is 32768, halving to 128
// - result saturates at both full-scale limits
`default_nettype none
module dsadc_ctrl
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire dsadc_pkg::dsadc_req_s req,
	output logic [7:0] rdata,
	// modulator side
	input wire logic mod_bit,
	output logic mod_reset,
	output logic chop_enable,
	output logic conv_clk_tick,
	// interrupt
	output logic irq
);
	import dsadc_pkg::*;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] ctl0_r, ctl1_r, mod_r, presc_r, dec_r, irqc_r;
	logic [23:0] result_r;
	logic publish;
	logic wr_ctl1, wr_irq;

	assign wr_ctl1 = req.wr && (req.addr == DSADC_A_CTL1);
	assign wr_irq = req.wr && (req.addr == DSADC_A_IRQ);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctl0_r <= DSADC_CTL0_RST;
			mod_r <= DSADC_MOD_RST;
			presc_r <= DSADC_PRESC_RST;
			dec_r <= DSADC_DEC_RST;
		end
		else if (req.wr)
		begin
			// reserved bits keep reset values
			unique case (req.addr)
				DSADC_A_CTL0: ctl0_r <= req.wdata & DSADC_CTL0_WMASK;
				DSADC_A_MOD: mod_r <= (req.wdata & DSADC_MOD_WMASK) |
					(DSADC_MOD_RST & ~DSADC_MOD_WMASK);
				DSADC_A_PRESC: presc_r <= req.wdata & DSADC_PRESC_WMASK;
				DSADC_A_DEC: dec_r <= (req.wdata & DSADC_DEC_WMASK) |
					(DSADC_DEC_RST & ~DSADC_DEC_WMASK);
				default:
				begin
				end
			endcase
		end
	end

	// control 1: divider, hold, end-of-conversion flag (set wins)
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			ctl1_r <= DSADC_CTL1_RST;
		else
		begin
			if (wr_ctl1)
				ctl1_r <= req.wdata & DSADC_CTL1_WMASK;
			if (publish)
				ctl1_r[DSADC_B_EOC] <= 1'b1;
			else if (wr_ctl1)
				ctl1_r[DSADC_B_EOC] <= req.wdata[DSADC_B_EOC] & ctl1_r[DSADC_B_EOC];
		end
	end

	// interrupt control: enables and request flag (set wins)
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irqc_r <= DSADC_IRQ_RST;
		else
		begin
			if (wr_irq)
				irqc_r[1:0] <= req.wdata[1:0];
			if (publish)
				irqc_r[DSADC_B_IRQ_FLAG] <= 1'b1;
			else if (wr_irq)
				irqc_r[DSADC_B_IRQ_FLAG] <= req.wdata[DSADC_B_IRQ_FLAG] &
					irqc_r[DSADC_B_IRQ_FLAG];
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (req.rd)
		begin
			unique case (req.addr)
				DSADC_A_CTL0: rdata <= ctl0_r;
				DSADC_A_CTL1: rdata <= ctl1_r;
				DSADC_A_MOD: rdata <= mod_r;
				DSADC_A_PRESC: rdata <= presc_r;
				DSADC_A_DEC: rdata <= dec_r;
				DSADC_A_IRQ: rdata <= irqc_r;
				DSADC_A_RES_L: rdata <= result_r[7:0];
				DSADC_A_RES_M: rdata <= result_r[15:8];
				DSADC_A_RES_H: rdata <= result_r[23:16];
				default: rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// ---------------------------------------------------------------
	// clock prescaler and fixed divider
	// ---------------------------------------------------------------
	logic [5:0] ps_cnt_r, ps_term;
	logic ps_tick_r;
	logic [4:0] n_cnt_r, n_term;

	assign ps_term = (presc_r[4:0] == DSADC_PRESC_FULL) ? 6'h00 : {presc_r[4:0], 1'b1};
	assign n_term = (ctl1_r[7:5] == DSADC_DIV12_CODE) ? DSADC_DIV12_TERM : DSADC_DIV30_TERM;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ps_cnt_r <= 6'h00;
			ps_tick_r <= 1'b0;
		end
		else
		begin
			ps_tick_r <= (ps_cnt_r >= ps_term);
			ps_cnt_r <= (ps_cnt_r >= ps_term) ? 6'h00 : ps_cnt_r + 6'h01;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			n_cnt_r <= 5'h00;
			conv_clk_tick <= 1'b0;
		end
		else
		begin
			conv_clk_tick <= ps_tick_r && (n_cnt_r >= n_term);
			if (ps_tick_r)
				n_cnt_r <= (n_cnt_r >= n_term) ? 5'h00 : n_cnt_r + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// conversion start and decimation
	// ---------------------------------------------------------------
	logic soft_rst_prev_r, running_r;
	logic [4:0] k_log;
	logic [16:0] smp_cnt_r, smp_term;
	logic signed [17:0] acc_r, acc_nxt;
	logic signed [24:0] scaled;
	logic [2:0] lat_cnt_r, lat_term;
	logic word_done;

	// reserved oversampling codes act as the fastest ratio
	assign k_log = DSADC_OSR_LOG_BASE -
		((ctl0_r[4:1] > DSADC_OSR_MAX_CODE) ? {1'b0, DSADC_OSR_MAX_CODE} : {1'b0, ctl0_r[4:1]}) +
		{4'h0, ~dec_r[DSADC_B_FILT]};
	assign smp_term = 17'((17'h00001 << k_log) - 17'h00001);
	assign acc_nxt = acc_r + (mod_bit ? 18'sd1 : -18'sd1);
	assign scaled = 25'(signed'({{7{acc_nxt[17]}}, acc_nxt}) <<< (DSADC_FULL_LOG - k_log));
	assign lat_term = dec_r[DSADC_B_FILT] ? DSADC_LAT_DECIMATOR_CONFIG : DSADC_LAT_SINC2;
	assign word_done = conv_clk_tick && running_r && !mod_r[DSADC_B_MOD_RST] &&
		(smp_cnt_r == smp_term);
	assign publish = word_done && (lat_cnt_r >= lat_term - 3'd1) &&
		!ctl1_r[DSADC_B_HOLD];

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			soft_rst_prev_r <= 1'b0;
			running_r <= 1'b0;
		end
		else
		begin
			soft_rst_prev_r <= ctl0_r[DSADC_B_SOFT_RST];
			if (ctl0_r[DSADC_B_SOFT_RST])
				running_r <= 1'b0;
			else if (soft_rst_prev_r)
				running_r <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || !running_r || ctl0_r[DSADC_B_SOFT_RST])
		begin
			smp_cnt_r <= 17'h00000;
			acc_r <= 18'sd0;
			lat_cnt_r <= 3'd0;
		end
		else if (conv_clk_tick && !mod_r[DSADC_B_MOD_RST])
		begin
			if (smp_cnt_r == smp_term)
			begin
				smp_cnt_r <= 17'h00000;
				acc_r <= 18'sd0;
				if (lat_cnt_r < lat_term - 3'd1)
					lat_cnt_r <= lat_cnt_r + 3'd1;
			end
			else
			begin
				smp_cnt_r <= smp_cnt_r + 17'h00001;
				acc_r <= acc_nxt;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			result_r <= 24'h000000;
		else if (publish)
		begin
			if (scaled > DSADC_POS_FS)
				result_r <= DSADC_POS_FS[23:0];
			else if (scaled < DSADC_NEG_FS)
				result_r <= DSADC_NEG_FS[23:0];
			else
				result_r <= scaled[23:0];
		end
	end

	// ---------------------------------------------------------------
	// modulator controls and interrupt output
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			mod_reset <= 1'b0;
			chop_enable <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			mod_reset <= mod_r[DSADC_B_MOD_RST];
			chop_enable <= !dec_r[DSADC_B_CHOP_DIS];
			irq <= irqc_r[DSADC_B_IRQ_FLAG] && irqc_r[DSADC_B_IRQ_EN] &&
				irqc_r[DSADC_B_GIE];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_mod_reset_follow: assert property (@(posedge sys_clk) disable iff (srst)
		mod_r[DSADC_B_MOD_RST] |=> mod_reset)
		else $error("modulator reset not driven");
	a_full_rate_src: assert property (@(posedge sys_clk) disable iff (srst)
		(presc_r[4:0] == DSADC_PRESC_FULL)[*3] |-> ps_tick_r)
		else $error("undivided source missing a tick");
	a_prescale_gap: assert property (@(posedge sys_clk) disable iff (srst)
		ps_tick_r && (presc_r[4:0] != DSADC_PRESC_FULL) && $stable(presc_r) |=> !ps_tick_r)
		else $error("divided source ticked twice in a row");
	a_divider_gap: assert property (@(posedge sys_clk) disable iff (srst)
		conv_clk_tick |=> !conv_clk_tick[*8])
		else $error("converter clock faster than divider allows");
	a_soft_hold: assert property (@(posedge sys_clk) disable iff (srst)
		ctl0_r[DSADC_B_SOFT_RST] |=> !running_r && !publish)
		else $error("filter ran during soft reset");
	a_start_pulse: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(ctl0_r[DSADC_B_SOFT_RST]) && !$rose(ctl0_r[DSADC_B_SOFT_RST]) |=> running_r)
		else $error("conversion did not start after pulse");
	a_eoc_set: assert property (@(posedge sys_clk) disable iff (srst)
		publish |=> ctl1_r[DSADC_B_EOC] && irqc_r[DSADC_B_IRQ_FLAG])
		else $error("end flag not set after word");
	a_eoc_sticky: assert property (@(posedge sys_clk) disable iff (srst)
		ctl1_r[DSADC_B_EOC] && !wr_ctl1 |=> ctl1_r[DSADC_B_EOC])
		else $error("end flag cleared without write");
	a_hold_keeps: assert property (@(posedge sys_clk) disable iff (srst)
		ctl1_r[DSADC_B_HOLD] |=> $stable(result_r))
		else $error("result changed while held");
	a_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
		irq |-> $past(irqc_r[DSADC_B_IRQ_EN]) && $past(irqc_r[DSADC_B_GIE]))
		else $error("interrupt raised without both enables");
	a_reserved_keep: assert property (@(posedge sys_clk) disable iff (srst)
		req.wr |=> (mod_r[6:0] == DSADC_MOD_RST[6:0]) && (dec_r[7:2] == DSADC_DEC_RST[7:2]))
		else $error("reserved bits changed");
endmodule
`default_nettype wire

// File: logic/dsadc_pkg.sv
// dsadc_pkg: constants and carriers for the delta-sigma converter control
// assumes one 100 MHz system clock and an 8-bit register port
`default_nettype none
package dsadc_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [3:0] DSADC_A_CTL0 = 4'h0;
	localparam logic [3:0] DSADC_A_CTL1 = 4'h1;
	localparam logic [3:0] DSADC_A_MOD = 4'h2;
	localparam logic [3:0] DSADC_A_PRESC = 4'h3;
	localparam logic [3:0] DSADC_A_DEC = 4'h4;
	localparam logic [3:0] DSADC_A_IRQ = 4'h5;
	localparam logic [3:0] DSADC_A_RES_L = 4'h6;
	localparam logic [3:0] DSADC_A_RES_M = 4'h7;
	localparam logic [3:0] DSADC_A_RES_H = 4'h8;
	// ---------------------------------------------------------------
	// reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [7:0] DSADC_CTL0_RST = 8'h00;
	localparam logic [7:0] DSADC_CTL0_WMASK = 8'hBE;
	localparam logic [7:0] DSADC_CTL1_RST = 8'h00;
	localparam logic [7:0] DSADC_CTL1_WMASK = 8'hE4;
	localparam logic [7:0] DSADC_MOD_RST = 8'h71;
	localparam logic [7:0] DSADC_MOD_WMASK = 8'h80;
	localparam logic [7:0] DSADC_PRESC_RST = 8'h00;
	localparam logic [7:0] DSADC_PRESC_WMASK = 8'h1F;
	localparam logic [7:0] DSADC_DEC_RST = 8'h93;
	localparam logic [7:0] DSADC_DEC_WMASK = 8'h03;
	localparam logic [7:0] DSADC_IRQ_RST = 8'h00;
	localparam logic [7:0] DSADC_IRQ_WMASK = 8'h03;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DSADC_B_SOFT_RST = 7;
	localparam int DSADC_B_HOLD = 2;
	localparam int DSADC_B_EOC = 1;
	localparam int DSADC_B_MOD_RST = 7;
	localparam int DSADC_B_FILT = 1;
	localparam int DSADC_B_CHOP_DIS = 0;
	localparam int DSADC_B_IRQ_EN = 0;
	localparam int DSADC_B_GIE = 1;
	localparam int DSADC_B_IRQ_FLAG = 2;
	// ---------------------------------------------------------------
	// counts
	// ---------------------------------------------------------------
	localparam logic [4:0] DSADC_PRESC_FULL = 5'h1F;
	localparam logic [2:0] DSADC_DIV12_CODE = 3'h2;
	localparam logic [4:0] DSADC_DIV12_TERM = 5'd11;
	localparam logic [4:0] DSADC_DIV30_TERM = 5'd29;
	localparam logic [3:0] DSADC_OSR_MAX_CODE = 4'h8;
	localparam logic [4:0] DSADC_OSR_LOG_BASE = 5'd15;
	localparam logic [4:0] DSADC_FULL_LOG = 5'd23;
	localparam logic [2:0] DSADC_LAT_SINC2 = 3'd3;
	localparam logic [2:0] DSADC_LAT_DECIMATOR_CONFIG = 3'd4;
	localparam logic signed [24:0] DSADC_POS_FS = 25'sh07FFFFF;
	localparam logic signed [24:0] DSADC_NEG_FS = -25'sh0800000;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dsadc_req_s;
endpackage
`default_nettype wire

// File: tb/dsadc_ctrl_test.sv
// dsadc_ctrl_test: self-checking bench for the converter control block
// assumes dsadc_pkg and dsadc_ctrl are compiled first
`default_nettype none
module dsadc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dsadc_pkg::*;
	// ---------------------------------------------------------------
	// design and stimulus
	// ---------------------------------------------------------------
	logic sys_clk, srst, mod_bit, mod_reset, chop_enable, conv_clk_tick, irq;
	dsadc_req_s req;
	logic [7:0] rdata;
	int err_total, n_tests, cyc;
	dsadc_ctrl dsadc_ctrl_i (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata),
		.mod_bit(mod_bit), .mod_reset(mod_reset), .chop_enable(chop_enable),
		.conv_clk_tick(conv_clk_tick), .irq(irq));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial cyc = 0;
	always @(posedge sys_clk) cyc <= cyc + 1;
	// ---------------------------------------------------------------
	// checks and bus cycles
	// ---------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tmo();
		err_total++;
		$display("[ERR] wait expected done seen timeout");
		close_out();
	endtask
	task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_n(input string w, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi)
		begin
			err_total++;
			$display("[ERR] %s expected %0d..%0d seen %0d", w, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge sys_clk);
		req.wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge sys_clk);
		req.rd <= 1'b0;
		@(posedge sys_clk);
		d = rdata;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk("register", e, d);
	endtask
	task automatic chk_res(input logic [23:0] e);
		logic [7:0] h, m, l;
		rd(DSADC_A_RES_H, h);
		rd(DSADC_A_RES_M, m);
		rd(DSADC_A_RES_L, l);
		chk("result", e, {h, m, l});
	endtask
	task automatic wait_tick();
		int i;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
			if (i > 400)
				tmo();
		end
		while (conv_clk_tick !== 1'b1);
	endtask
	task automatic wait_eoc();
		logic [7:0] d;
		int t0;
		t0 = cyc;
		d = 8'h00;
		while (d[DSADC_B_EOC] !== 1'b1)
		begin
			if (cyc - t0 > 20000)
				tmo();
			rd(DSADC_A_CTL1, d);
		end
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		logic [3:0] a [7];
		logic [7:0] e [7];
		a = '{DSADC_A_CTL0, DSADC_A_CTL1, DSADC_A_MOD, DSADC_A_PRESC, DSADC_A_DEC,
			DSADC_A_IRQ, 4'hF};
		e = '{8'h00, 8'h00, 8'h71, 8'h00, 8'h93, 8'h00, 8'h00};
		foreach (a[i]) chk_rd(a[i], e[i]);
		wr(DSADC_A_MOD, 8'hFF);
		wr(DSADC_A_PRESC, 8'hFF);
		wr(DSADC_A_DEC, 8'h00);
		wr(4'hF, 8'hFF);
		chk("mod_reset", 1'b1, mod_reset);
		chk("chop_enable", 1'b1, chop_enable);
		e = '{8'h00, 8'h00, 8'hF1, 8'h1F, 8'h90, 8'h00, 8'h00};
		foreach (a[i]) chk_rd(a[i], e[i]);
		wr(DSADC_A_MOD, 8'h00);
		wr(DSADC_A_DEC, 8'hFF);
		// outputs follow the registers one edge later
		@(posedge sys_clk);
		chk("mod_reset", 1'b0, mod_reset);
		chk("chop_enable", 1'b0, chop_enable);
		$display("done registers");
	endtask
	task automatic t_tick(input logic [7:0] p, input logic [7:0] n, input int e);
		int t0;
		wr(DSADC_A_PRESC, p);
		wr(DSADC_A_CTL1, n);
		wait_tick();
		wait_tick();
		t0 = cyc;
		wait_tick();
		chk_n("tick period", e, e, cyc - t0);
		$display("done tick %0d", e);
	endtask
	task automatic t_conv3();
		int t0;
		mod_bit <= 1'b1;
		wr(DSADC_A_CTL0, 8'h90);
		wr(DSADC_A_CTL0, 8'h10);
		t0 = cyc;
		wait_eoc();
		chk_n("first word", 3 * 1536 + 1, 4 * 1536 + 40, cyc - t0);
		chk_res(24'h7FFFFF);
		chk_rd(DSADC_A_IRQ, 8'h04);
		wr(DSADC_A_IRQ, 8'h05);
		@(posedge sys_clk);
		chk("irq", 1'b0, irq);
		wr(DSADC_A_IRQ, 8'h07);
		@(posedge sys_clk);
		chk("irq", 1'b1, irq);
		chk_rd(DSADC_A_CTL1, 8'h42);
		$display("done third order");
	endtask
	task automatic t_hold();
		mod_bit <= 1'b0;
		wr(DSADC_A_CTL1, 8'h44);
		wr(DSADC_A_IRQ, 8'h03);
		@(posedge sys_clk);
		chk("irq", 1'b0, irq);
		repeat (7700) @(posedge sys_clk);
		chk_rd(DSADC_A_CTL1, 8'h44);
		chk_rd(DSADC_A_IRQ, 8'h03);
		chk_res(24'h7FFFFF);
		wr(DSADC_A_CTL1, 8'h40);
		wait_eoc();
		chk("irq", 1'b1, irq);
		chk_res(24'h800000);
		$display("done hold");
	endtask
	task automatic t_conv2();
		int t0;
		wr(DSADC_A_IRQ, 8'h00);
		wr(DSADC_A_DEC, 8'h90);
		wr(DSADC_A_CTL0, 8'h8E);
		mod_bit <= 1'b1;
		wr(DSADC_A_CTL1, 8'h40);
		chk("chop_enable", 1'b1, chop_enable);
		repeat (10000) @(posedge sys_clk);
		chk_rd(DSADC_A_CTL1, 8'h40);
		wr(DSADC_A_CTL0, 8'h0E);
		t0 = cyc;
		wait_eoc();
		chk_n("first word", 2 * 6144 + 1, 3 * 6144 + 40, cyc - t0);
		chk_res(24'h7FFFFF);
		$display("done second order");
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		srst = 1'b1;
		mod_bit = 1'b0;
		req = '0;
		err_total = 0;
		n_tests = 0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		t_regs();
		t_tick(8'h1F, 8'h00, 30);
		t_tick(8'h02, 8'h40, 72);
		t_tick(8'h00, 8'h40, 24);
		t_tick(8'h0B, 8'h40, 288);
		t_tick(8'h1F, 8'h40, 12);
		t_conv3();
		t_hold();
		t_conv2();
		close_out();
	end
endmodule
`default_nettype wire
